// >>> core/ldc_host.sv
// Host end: serial word shifter, latch and gate control, direct dimming drive
`timescale 1ns/1ps
`default_nettype none
module ldc_host
	import ldc_pkg::*;
(
	input  wire logic                  i_clk_sys,
	input  wire logic                  i_rst_n,
	input  wire logic                  i_send,
	input  wire logic [2:0]            i_word,
	input  wire logic                  i_latch_after,
	input  wire logic                  i_hold_latch_open,
	input  wire logic                  i_gate_n,
	input  wire logic [2:0]            i_pwm,
	output logic                       o_busy,
	output logic                       o_done,
	output logic                       o_cascade,
	ldc_link_if.host                   link
);
	// ---------------------------------------------------------------
	// Serial clock divider and shifter
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_HIGH, ST_LATCH} ldc_hst_e;
	ldc_hst_e   state_reg;
	logic [2:0] word_reg;
	logic [1:0] bit_reg;
	logic [3:0] div_reg;
	logic       tick;
	assign tick = (div_reg == 4'(LDC_SCLK_HALF_CYC - 1));
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n || state_reg == ST_IDLE || tick) begin
			div_reg <= 4'h0;
		end else begin
			div_reg <= div_reg + 4'h1;
		end
	end
	// MSB sent first on data pin
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			state_reg <= ST_IDLE;
			word_reg  <= 3'h0;
			bit_reg   <= 2'h0;
			o_done    <= 1'b0;
		end else begin
			o_done <= 1'b0;
			case (state_reg)
				ST_IDLE: begin
					if (i_send) begin
						word_reg  <= i_word;
						bit_reg   <= 2'h0;
						state_reg <= ST_LOW;
					end
				end
				ST_LOW: if (tick) begin
					state_reg <= ST_HIGH;
				end
				ST_HIGH: if (tick) begin
					word_reg <= {word_reg[1:0], 1'b0};
					if (bit_reg == 2'h2) begin
						state_reg <= i_latch_after ? ST_LATCH : ST_IDLE;
						o_done    <= !i_latch_after;
					end else begin
						bit_reg   <= bit_reg + 2'h1;
						state_reg <= ST_LOW;
					end
				end
				ST_LATCH: if (tick) begin
					state_reg <= ST_IDLE;
					o_done    <= 1'b1;
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end
	assign o_busy = (state_reg != ST_IDLE);
	// ---------------------------------------------------------------
	// Pin drive
	// ---------------------------------------------------------------
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			link.serial_data        <= 1'b0;
			link.serial_clk         <= 1'b0;
			link.latch_pass_control <= 1'b0;
			link.out_gate_n         <= 1'b1;
			link.pwm_in             <= 3'h0;
		end else begin
			link.serial_data <= word_reg[2];
			link.serial_clk  <= (state_reg == ST_HIGH);
			// Hold latch open for gate dimming
			link.latch_pass_control <= i_hold_latch_open || (state_reg == ST_LATCH);
			link.out_gate_n <= i_gate_n;
			link.pwm_in <= i_pwm;
		end
	end
	logic [1:0] casc_sync_reg;
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			casc_sync_reg <= 2'h0;
		end else begin
			casc_sync_reg <= {casc_sync_reg[0], link.cascade_out};
		end
	end
	assign o_cascade = casc_sync_reg[1];
endmodule : ldc_host
`default_nettype wire

// >>> shared/ldc_pkg.sv
// Package of constants and types shared by both ends of the LED dimming link
package ldc_pkg;
	// ---------------------------------------------------------------
	// Geometry
	// ---------------------------------------------------------------
	localparam int unsigned LDC_CHANNELS = 3;
	localparam int unsigned LDC_WORD_BITS = 3;
	localparam int unsigned LDC_CASCADE_DELAY = 3;
	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic [2:0] LDC_SHIFT_RST = 3'h0;
	localparam logic [2:0] LDC_LATCH_RST = 3'h0;
	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int unsigned LDC_CLK_HZ = 40000000;
	localparam int unsigned LDC_PWM_MAX_HZ = 5000;
	// Shortest legal dimming period in system clock cycles (rounded up)
	localparam int unsigned LDC_PWM_MIN_CYC = (LDC_CLK_HZ + LDC_PWM_MAX_HZ - 1) / LDC_PWM_MAX_HZ;
	// Host serial clock half period in system cycles
	localparam int unsigned LDC_SCLK_HALF_CYC = 4;
	typedef enum logic [1:0] {
		LDC_MODE_LATCH,
		LDC_MODE_GATE,
		LDC_MODE_DIRECT
	} ldc_mode_e;
endpackage : ldc_pkg

// >>> shared/ldc_link_if.sv
// Interface carrying the serial control pins between host and driver
`timescale 1ns/1ps
`default_nettype none
interface ldc_link_if;
	logic       serial_data;
	logic       serial_clk;
	logic       latch_pass_control;
	logic       out_gate_n;
	logic       cascade_out;
	logic [2:0] pwm_in;
	modport device (
		input  serial_data,
		input  serial_clk,
		input  latch_pass_control,
		input  out_gate_n,
		input  pwm_in,
		output cascade_out
	);
	modport host (
		output serial_data,
		output serial_clk,
		output latch_pass_control,
		output out_gate_n,
		output pwm_in,
		input  cascade_out
	);
endinterface : ldc_link_if
`default_nettype wire

// >>> core/ldc_device.sv
// Driver end: serial shift register, transparent latch, output gate, direct dimming inputs
`timescale 1ns/1ps
`default_nettype none
module ldc_device
	import ldc_pkg::*;
#(
	parameter bit SERIAL_VARIANT = 1'b1
) (
	input  wire logic                    i_clk_sys,
	input  wire logic                    i_rst_n,
	ldc_link_if.device                   link,
	output logic [LDC_CHANNELS-1:0]      o_sink_on,
	output logic [LDC_CHANNELS-1:0]      o_sink_hiz,
	output logic [LDC_WORD_BITS-1:0]     o_latched
);
	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	logic [6:0] sync1_reg;
	logic [6:0] sync2_reg;
	logic       sclk_prev_reg;
	// Gate bit resets to its idle high level, so outputs stay off after reset release
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			sync1_reg <= 7'h08;
			sync2_reg <= 7'h08;
		end else begin
			sync1_reg <= {link.pwm_in, link.out_gate_n, link.latch_pass_control,
				link.serial_clk, link.serial_data};
			sync2_reg <= sync1_reg;
		end
	end
	logic       din_s;
	logic       sclk_s;
	logic       lpc_s;
	logic       gate_n_s;
	logic [2:0] pwm_s;
	assign din_s    = sync2_reg[0];
	assign sclk_s   = sync2_reg[1];
	assign lpc_s    = sync2_reg[2];
	assign gate_n_s = sync2_reg[3];
	assign pwm_s    = sync2_reg[6:4];
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			sclk_prev_reg <= 1'b0;
		end else begin
			sclk_prev_reg <= sclk_s;
		end
	end
	logic sclk_rise;
	assign sclk_rise = sclk_s & ~sclk_prev_reg;
	// ---------------------------------------------------------------
	// Shift register
	// ---------------------------------------------------------------
	logic [LDC_WORD_BITS-1:0] shift_reg;
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			shift_reg <= LDC_SHIFT_RST;
		end else if (sclk_rise) begin
			shift_reg <= {shift_reg[LDC_WORD_BITS-2:0], din_s};
		end
	end
	assign link.cascade_out = shift_reg[LDC_WORD_BITS-1];
	// ---------------------------------------------------------------
	// Output latch
	// ---------------------------------------------------------------
	logic [LDC_WORD_BITS-1:0] latch_reg;
	// Follows each shifted bit
	// Capture on falling edge is the value held in the last open cycle
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			latch_reg <= LDC_LATCH_RST;
		end else if (lpc_s) begin
			latch_reg <= sclk_rise ? {shift_reg[LDC_WORD_BITS-2:0], din_s} : shift_reg;
		end
	end
	assign o_latched = latch_reg;
	// ---------------------------------------------------------------
	// Channel outputs
	// ---------------------------------------------------------------
	// Channel 1 takes the last shifted bit, channel 3 the first
	// All channels in one register
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			o_sink_on  <= '0;
			o_sink_hiz <= {LDC_CHANNELS{1'b1}};
		end else if (SERIAL_VARIANT) begin
			o_sink_hiz <= {LDC_CHANNELS{gate_n_s}};
			o_sink_on  <= gate_n_s ? '0 : latch_reg;
		end else begin
			o_sink_hiz <= ~pwm_s;
			o_sink_on  <= pwm_s;
		end
	end
endmodule : ldc_device
`default_nettype wire

// >>> tb/ldc_link_assertions.sv
// Concurrent checks on the serial link between host and driver
`timescale 1ns/1ps
`default_nettype none
module ldc_link_assertions
	import ldc_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic serial_data,
	input wire logic serial_clk,
	input wire logic latch_pass_control,
	input wire logic cascade_out
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);
	logic [2:0] shift_reg;
	// Mirror of the driver's shift register, so cascade data is checked and not only timing
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			shift_reg <= LDC_SHIFT_RST;
		end else if ($rose(serial_clk)) begin
			shift_reg <= {shift_reg[1:0], serial_data};
		end
	end
	chk_cascade_mirror: assert property ($past(serial_clk, 3) && !$past(serial_clk, 4)
		|-> cascade_out == shift_reg[2]) else $error("cascade differs from third shifted bit");
	chk_cascade_quiet: assert property ($changed(cascade_out)
		|-> $past(serial_clk, 3) && !$past(serial_clk, 4)) else $error("cascade moved without shift");
	chk_clk_high_width: assert property ($rose(serial_clk)
		|=> serial_clk [*3] ##1 !serial_clk) else $error("serial clock high width wrong");
	chk_clk_low_width: assert property ($fell(serial_clk)
		|=> !serial_clk [*3]) else $error("serial clock low too short");
	chk_data_held_high: assert property (serial_clk && $past(serial_clk)
		|-> $stable(serial_data)) else $error("serial data moved while clock high");
	chk_latch_min_width: assert property ($rose(latch_pass_control)
		|=> latch_pass_control) else $error("latch pulse too short");
	chk_latch_rise_idle: assert property ($rose(latch_pass_control)
		|-> !serial_clk) else $error("latch opened while clock high");
	chk_latch_fall_idle: assert property ($fell(latch_pass_control)
		|-> !serial_clk) else $error("latch closed while clock high");
endmodule : ldc_link_assertions
`default_nettype wire

// >>> tb/testbench.sv
// Self-checking bench joining host and driver ends, plus a direct-variant driver
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import ldc_pkg::*;
	logic       clk = 0, rst_n = 0, send = 0, lat = 0, hold = 0, gate_n = 0, watch = 0;
	logic [2:0] word = 3'h0, pwm = 3'h0;
	logic       busy, done, casc;
	logic [2:0] on, hiz, lt, on_d, hiz_d;
	int         fail_count = 0, check_count = 0;
	// Each row: word sent, channels expected on
	logic [5:0] rows [6] = '{6'h2d, 6'h12, 6'h3f, 6'h00, 6'h09, 6'h24};
	ldc_link_if link ();
	ldc_link_if link_dir ();
	always #12.5 clk = ~clk;
	ldc_host u_ldc_host (.i_clk_sys(clk), .i_rst_n(rst_n), .i_send(send), .i_word(word),
		.i_latch_after(lat), .i_hold_latch_open(hold), .i_gate_n(gate_n), .i_pwm(pwm),
		.o_busy(busy), .o_done(done), .o_cascade(casc), .link(link));
	ldc_device u_ldc_device (.i_clk_sys(clk), .i_rst_n(rst_n), .link(link),
		.o_sink_on(on), .o_sink_hiz(hiz), .o_latched(lt));
	ldc_device #(.SERIAL_VARIANT(1'b0)) u_ldc_device_dir (.i_clk_sys(clk), .i_rst_n(rst_n),
		.link(link_dir), .o_sink_on(on_d), .o_sink_hiz(hiz_d), .o_latched());
	assign link_dir.serial_data = 1'b0;
	assign link_dir.serial_clk = 1'b0;
	assign link_dir.latch_pass_control = 1'b0;
	assign link_dir.out_gate_n = 1'b0;
	assign link_dir.pwm_in = pwm;
	ldc_link_assertions u_ldc_link_assertions (.i_clk_sys(clk), .i_rst_n(rst_n),
		.serial_data(link.serial_data), .serial_clk(link.serial_clk),
		.latch_pass_control(link.latch_pass_control), .cascade_out(link.cascade_out));
	task automatic chk(input string n, input logic [2:0] s, input logic [2:0] e);
		check_count++;
		if (s !== e) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task automatic put(input logic [2:0] w, input logic l);
		int i;
		word = w;
		lat = l;
		send = 1;
		tick(1);
		send = 0;
		chk("busy_start", {2'h0, busy}, 3'h1);
		for (i = 0; i < 200 && done !== 1'b1; i++) tick(1);
		chk("done", {2'h0, done}, 3'h1);
		tick(6);
		chk("busy_end", {2'h0, busy}, 3'h0);
	endtask : put
	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : summarize
	// Outputs may only hold the old or the new word while a pattern is latched
	always @(negedge clk) begin
		if (watch && on !== 3'h2 && on !== 3'h5) chk("sink_together", on, 3'h5);
	end
	initial begin
		tick(3);
		rst_n = 1;
		foreach (rows[r]) begin
			put(rows[r][5:3], 1'b1);
			chk("latched", lt, rows[r][5:3]);
			chk("sink_on", on, rows[r][2:0]);
			chk("sink_hiz", hiz, 3'h0);
		end
		put(3'h2, 1'b1);
		watch = 1;
		put(3'h5, 1'b1);
		watch = 0;
		gate_n = 1;
		put(3'h3, 1'b1);
		chk("hiz_gated", hiz, 3'h7);
		chk("on_gated", on, 3'h0);
		chk("latch_gated", lt, 3'h3);
		gate_n = 0;
		tick(6);
		chk("on_ungated", on, 3'h3);
		put(3'h4, 1'b0);
		chk("latch_held", lt, 3'h3);
		chk("cascade", {2'h0, casc}, 3'h1);
		hold = 1;
		tick(6);
		chk("latch_open", lt, 3'h4);
		put(3'h6, 1'b0);
		chk("on_open", on, 3'h6);
		hold = 0;
		for (int p = 0; p < 8; p++) begin
			pwm = p[2:0];
			tick(4);
			chk("dir_on", on_d, p[2:0]);
			chk("dir_hiz", hiz_d, ~p[2:0]);
		end
		rst_n = 0;
		tick(3);
		chk("rst_on", on, 3'h0);
		chk("rst_hiz", hiz, 3'h7);
		chk("rst_latch", lt, LDC_LATCH_RST);
		rst_n = 1;
		put(3'h1, 1'b1);
		chk("after_rst", on, 3'h1);
		summarize();
	end
	// About nine times the expected run
	initial begin
		#100000;
		fail_count++;
		summarize();
	end
endmodule : testbench
`default_nettype wire
